// *** itc_counter.sv ***
// One 16-bit down-counter channel with six operating modes.
module itc_counter
    import itc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       cntClk,
    input  wire logic       gate,
    input  wire logic       ctrlWrite,
    input  wire itc_ctrl_s  ctrlWord,
    input  wire logic       dataWrite,
    input  wire logic [7:0] dataIn,
    input  wire logic       dataRead,
    output logic      [7:0] readData,
    output logic            cntOut
);

    itc_mode_e   mode_r;
    itc_mode_e   mode_nxt;
    itc_mode_e   newMode;
    logic [1:0]  fmt_r;
    logic [1:0]  fmt_nxt;
    itc_state_e  state_r;
    itc_state_e  state_nxt;
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic [16:0] counter_r;
    logic [16:0] counter_nxt;
    logic        out_r;
    logic        out_nxt;
    logic        lowDone_r;
    logic        lowDone_nxt;
    logic        hasCount_r;
    logic        hasCount_nxt;
    logic        nullCount_r;
    logic        nullCount_nxt;
    logic        tick;
    logic        gateTrig;
    logic        progCmd;
    logic        latchCmd;
    logic        loadDone;
    logic        gated;
    logic        triggered;
    logic [16:0] eff;
    logic [16:0] loadVal;

    itc_edge u_edge (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .cntClk   (cntClk),
        .gate     (gate),
        .tick     (tick),
        .gateTrig (gateTrig)
    );

    assign latchCmd = ctrlWrite & (ctrlWord.byteAccessFormat == FMT_LATCH);
    assign progCmd  = ctrlWrite & (ctrlWord.byteAccessFormat != FMT_LATCH);

    itc_readback u_readback (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .liveValue (nullCount_r ? count_r : counter_r[15:0]),
        .latchCmd  (latchCmd),
        .progCmd   (progCmd),
        .dataRead  (dataRead),
        .fmt       (fmt_r),
        .readData  (readData)
    );

    always_comb begin
        case (ctrlWord.mode)
            3'h0:        newMode = MODE_TC;
            3'h1:        newMode = MODE_ONESHOT;
            3'h2, 3'h6:  newMode = MODE_RATE;
            3'h3, 3'h7:  newMode = MODE_SQUARE;
            3'h4:        newMode = MODE_SWSTROBE;
            default:     newMode = MODE_HWSTROBE;
        endcase
    end

    always_comb begin
        mode_nxt      = mode_r;
        fmt_nxt       = fmt_r;
        state_nxt     = state_r;
        count_nxt     = count_r;
        counter_nxt   = counter_r;
        out_nxt       = out_r;
        lowDone_nxt   = lowDone_r;
        hasCount_nxt  = hasCount_r;
        nullCount_nxt = nullCount_r;
        loadDone      = 1'b0;
        gated         = (mode_r == MODE_TC) || (mode_r == MODE_SWSTROBE) ||
                        (mode_r == MODE_RATE) || (mode_r == MODE_SQUARE);
        triggered     = (mode_r != MODE_TC);
        if (count_r == COUNT_RESET) begin
            eff = FULL_COUNT;
        end else if (mode_r == MODE_SQUARE && count_r == CNT_ONE[15:0]) begin
            eff = SQUARE_ONE_COUNT;
        end else begin
            eff = {1'b0, count_r};
        end
        loadVal = (mode_r == MODE_SQUARE) ? eff + {16'h0000, eff[0]} : eff;
        if (tick) begin
            case (state_r)
                ST_ARMED: begin
                    if (!gated || gate) begin
                        counter_nxt   = loadVal;
                        state_nxt     = ST_RUN;
                        nullCount_nxt = 1'b0;
                        if (mode_r == MODE_ONESHOT) begin
                            out_nxt = 1'b0;
                        end
                        if (mode_r == MODE_SQUARE) begin
                            out_nxt = 1'b1;
                        end
                    end
                end
                ST_RUN: begin
                    case (mode_r)
                        MODE_TC, MODE_ONESHOT: begin
                            if (gate || mode_r == MODE_ONESHOT) begin
                                if (counter_r == CNT_ONE) begin
                                    counter_nxt = CNT_ZERO;
                                    out_nxt     = 1'b1;
                                    state_nxt   = ST_IDLE;
                                end else begin
                                    counter_nxt = counter_r - CNT_ONE;
                                end
                            end
                        end
                        MODE_SWSTROBE, MODE_HWSTROBE: begin
                            if (gate || mode_r == MODE_HWSTROBE) begin
                                if (counter_r == CNT_ONE) begin
                                    counter_nxt = CNT_ZERO;
                                    out_nxt     = 1'b0;
                                end else if (counter_r == CNT_ZERO) begin
                                    out_nxt   = 1'b1;
                                    state_nxt = ST_IDLE;
                                end else begin
                                    counter_nxt = counter_r - CNT_ONE;
                                end
                            end
                        end
                        MODE_RATE: begin
                            if (counter_r == CNT_TWO) begin
                                counter_nxt = CNT_ONE;
                                out_nxt     = 1'b0;
                            end else if (counter_r == CNT_ONE) begin
                                counter_nxt = eff;
                                out_nxt     = 1'b1;
                            end else begin
                                counter_nxt = counter_r - CNT_ONE;
                            end
                        end
                        default: begin
                            if (counter_r == CNT_TWO) begin
                                out_nxt     = ~out_r;
                                counter_nxt = out_r ? eff - {16'h0000, eff[0]} :
                                                      eff + {16'h0000, eff[0]};
                            end else begin
                                counter_nxt = counter_r - CNT_TWO;
                            end
                        end
                    endcase
                end
                default: begin
                end
            endcase
            if (gateTrig && triggered && hasCount_r) begin
                state_nxt = ST_ARMED;
            end
        end
        if ((mode_r == MODE_RATE || mode_r == MODE_SQUARE) && !gate) begin
            out_nxt   = 1'b1;
            state_nxt = ST_IDLE;
        end
        if (dataWrite) begin
            case (fmt_r)
                FMT_LSB: begin
                    count_nxt = {8'h00, dataIn};
                    loadDone  = 1'b1;
                end
                FMT_MSB: begin
                    count_nxt = {dataIn, 8'h00};
                    loadDone  = 1'b1;
                end
                default: begin
                    if (!lowDone_r) begin
                        count_nxt   = {count_r[15:8], dataIn};
                        lowDone_nxt = 1'b1;
                        if (mode_r == MODE_TC) begin
                            state_nxt = ST_IDLE;
                        end
                    end else begin
                        count_nxt   = {dataIn, count_r[7:0]};
                        lowDone_nxt = 1'b0;
                        loadDone    = 1'b1;
                    end
                end
            endcase
            if (loadDone) begin
                hasCount_nxt = 1'b1;
                if (mode_r == MODE_TC || mode_r == MODE_SWSTROBE) begin
                    state_nxt = ST_ARMED;
                end else if ((mode_r == MODE_RATE || mode_r == MODE_SQUARE) &&
                             state_r != ST_RUN && gate) begin
                    state_nxt = ST_ARMED;
                end
            end
        end
        if (progCmd) begin
            mode_nxt      = newMode;
            fmt_nxt       = ctrlWord.byteAccessFormat;
            state_nxt     = ST_IDLE;
            counter_nxt   = CNT_ZERO;
            out_nxt       = (newMode != MODE_TC);
            lowDone_nxt   = 1'b0;
            hasCount_nxt  = 1'b0;
            nullCount_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mode_r      <= MODE_TC;
            fmt_r       <= FMT_RESET;
            state_r     <= ST_IDLE;
            count_r     <= COUNT_RESET;
            counter_r   <= CNT_ZERO;
            out_r       <= 1'b1;
            lowDone_r   <= 1'b0;
            hasCount_r  <= 1'b0;
            nullCount_r <= 1'b1;
        end else begin
            mode_r      <= mode_nxt;
            fmt_r       <= fmt_nxt;
            state_r     <= state_nxt;
            count_r     <= count_nxt;
            counter_r   <= counter_nxt;
            out_r       <= out_nxt;
            lowDone_r   <= lowDone_nxt;
            hasCount_r  <= hasCount_nxt;
            nullCount_r <= nullCount_nxt;
        end
    end

    assign cntOut = out_r;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    sequence tcEndTick;
        mode_r == MODE_TC && state_r == ST_RUN && tick && gate && counter_r == CNT_ONE;
    endsequence

    sequence sqRunTick;
        mode_r == MODE_SQUARE && state_r == ST_RUN && tick && gate && !dataWrite;
    endsequence

    AST_TC_PROGRAM_LOW: assert property (
        progCmd && ctrlWord.mode == MODE_RESET |=> !cntOut)
        else $error("Mode 0 programming did not drive output low.");

    AST_TC_HIGH_AT_END: assert property (
        tcEndTick and !ctrlWrite and !dataWrite |=> cntOut ##1 cntOut || $past(ctrlWrite))
        else $error("Terminal count did not raise the output.");

    AST_TC_STAYS_HIGH: assert property (
        mode_r == MODE_TC && cntOut && !ctrlWrite |=> cntOut)
        else $error("Mode 0 output fell without reprogramming.");

    AST_GATE_SUSPEND: assert property (
        (mode_r == MODE_TC || mode_r == MODE_SWSTROBE) && state_r == ST_RUN && !gate &&
        !ctrlWrite && !dataWrite |=> $stable(counter_r))
        else $error("Counter moved while gate was low.");

    AST_ONESHOT_LOW: assert property (
        mode_r == MODE_ONESHOT && state_r == ST_ARMED && tick && !ctrlWrite
        |=> !cntOut && counter_r == $past(eff))
        else $error("One-shot did not start low with the count.");

    AST_GATE_FORCE_HIGH: assert property (
        (mode_r == MODE_RATE || mode_r == MODE_SQUARE) && !gate && !ctrlWrite
        |=> cntOut && state_r == ST_IDLE)
        else $error("Gate low did not force the output high.");

    AST_RATE_PULSE: assert property (
        mode_r == MODE_RATE && state_r == ST_RUN && tick && gate && counter_r == CNT_TWO &&
        !ctrlWrite |=> !cntOut && counter_r == CNT_ONE)
        else $error("Rate pulse did not appear.");

    AST_SQ_DECR: assert property (
        sqRunTick and counter_r != CNT_TWO and !ctrlWrite
        |=> counter_r == $past(counter_r) - CNT_TWO)
        else $error("Square wave did not step by two.");

endmodule : itc_counter

// *** itc_pkg.sv ***
// Shared types and constants of the interval timer counter.
package itc_pkg;

    typedef enum logic [2:0] {
        MODE_TC,
        MODE_ONESHOT,
        MODE_RATE,
        MODE_SQUARE,
        MODE_SWSTROBE,
        MODE_HWSTROBE
    } itc_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_RUN
    } itc_state_e;

    typedef struct packed {
        logic [2:0] mode;
        logic [1:0] byteAccessFormat;
    } itc_ctrl_s;

    localparam logic [1:0]  FMT_LATCH        = 2'h0;
    localparam logic [1:0]  FMT_LSB          = 2'h1;
    localparam logic [1:0]  FMT_MSB          = 2'h2;
    localparam logic [1:0]  FMT_BOTH         = 2'h3;
    localparam logic [16:0] FULL_COUNT       = 17'h10000;
    localparam logic [16:0] SQUARE_ONE_COUNT = 17'h10001;
    localparam logic [16:0] CNT_ZERO         = 17'h00000;
    localparam logic [16:0] CNT_ONE          = 17'h00001;
    localparam logic [16:0] CNT_TWO          = 17'h00002;
    localparam logic [15:0] COUNT_RESET      = 16'h0000;
    localparam logic [2:0]  MODE_RESET       = 3'h0;
    localparam logic [1:0]  FMT_RESET        = 2'h1;
    localparam logic [7:0]  READ_RESET       = 8'h00;

endpackage : itc_pkg

// *** itc_edge.sv ***
// Counter clock edge detection and gate rising edge capture.
module itc_edge
    import itc_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic cntClk,
    input  wire logic gate,
    output logic      tick,
    output logic      gateTrig
);

    logic clkPrev_r;
    logic clkPrev_nxt;
    logic gatePrev_r;
    logic gatePrev_nxt;
    logic risePend_r;
    logic risePend_nxt;
    logic riseNow;

    always_comb begin
        riseNow      = gate & ~gatePrev_r;
        tick         = cntClk & ~clkPrev_r;
        gateTrig     = tick & (risePend_r | riseNow);
        clkPrev_nxt  = cntClk;
        gatePrev_nxt = gate;
        risePend_nxt = riseNow | (risePend_r & ~tick);
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            clkPrev_r  <= 1'b0;
            gatePrev_r <= 1'b1;
            risePend_r <= 1'b0;
        end else begin
            clkPrev_r  <= clkPrev_nxt;
            gatePrev_r <= gatePrev_nxt;
            risePend_r <= risePend_nxt;
        end
    end

endmodule : itc_edge

// *** itc_readback.sv ***
// Count latch and byte-wise read-back path.
module itc_readback
    import itc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic [15:0] liveValue,
    input  wire logic        latchCmd,
    input  wire logic        progCmd,
    input  wire logic        dataRead,
    input  wire logic [1:0]  fmt,
    output logic      [7:0]  readData
);

    logic        latched_r;
    logic        latched_nxt;
    logic [15:0] latchVal_r;
    logic [15:0] latchVal_nxt;
    logic        readHigh_r;
    logic        readHigh_nxt;
    logic [7:0]  readData_r;
    logic [7:0]  readData_nxt;
    logic [15:0] src;
    logic        lastByte;

    always_comb begin
        latched_nxt  = latched_r;
        latchVal_nxt = latchVal_r;
        readHigh_nxt = readHigh_r;
        readData_nxt = readData_r;
        src          = latched_r ? latchVal_r : liveValue;
        lastByte     = (fmt != FMT_BOTH) | readHigh_r;
        if (dataRead) begin
            if (fmt == FMT_MSB || (fmt == FMT_BOTH && readHigh_r)) begin
                readData_nxt = src[15:8];
            end else begin
                readData_nxt = src[7:0];
            end
            readHigh_nxt = (fmt == FMT_BOTH) & ~readHigh_r;
            if (lastByte) begin
                latched_nxt = 1'b0;
            end
        end
        if (latchCmd && !latched_r) begin
            latched_nxt  = 1'b1;
            latchVal_nxt = liveValue;
        end
        if (progCmd) begin
            latched_nxt  = 1'b0;
            readHigh_nxt = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            latched_r  <= 1'b0;
            latchVal_r <= COUNT_RESET;
            readHigh_r <= 1'b0;
            readData_r <= READ_RESET;
        end else begin
            latched_r  <= latched_nxt;
            latchVal_r <= latchVal_nxt;
            readHigh_r <= readHigh_nxt;
            readData_r <= readData_nxt;
        end
    end

    assign readData = readData_r;

    AST_LATCH_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
        latched_r && !latchCmd |=> $stable(latchVal_r))
        else $error("Latched count changed while held.");

endmodule : itc_readback

// *** itc_host_model.sv ***
// Host processor model that writes and reads one counter over its byte bus.
module itc_host_model
    import itc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic [7:0] readData,
    output logic            ctrlWrite,
    output itc_ctrl_s       ctrlWord,
    output logic            dataWrite,
    output logic      [7:0] dataIn,
    output logic            dataRead
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        ctrlWrite = 1'b0;
        ctrlWord  = '0;
        dataWrite = 1'b0;
        dataIn    = 8'h00;
        dataRead  = 1'b0;
    end

    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask : step

    task automatic wrCtrl(input logic [2:0] mode, input logic [1:0] fmt);
        step();
        ctrlWrite = 1'b1;
        ctrlWord  = '{mode: mode, byteAccessFormat: fmt};
        step();
        ctrlWrite = 1'b0;
        ctrlWord  = ~ctrlWord;
    endtask : wrCtrl

    task automatic wrByte(input logic [7:0] b);
        step();
        dataWrite = 1'b1;
        dataIn    = b;
        step();
        dataWrite = 1'b0;
        dataIn    = ~b;
    endtask : wrByte

    task automatic wrWord(input logic [15:0] w);
        wrByte(w[7:0]);
        wrByte(w[15:8]);
    endtask : wrWord

    task automatic rdByte(output logic [7:0] b);
        step();
        dataRead = 1'b1;
        step();
        dataRead = 1'b0;
        b        = readData;
    endtask : rdByte

endmodule : itc_host_model

// *** test_interval_timer_counter_modes.sv ***
// Self-checking testbench of one interval timer counter channel.
module test_interval_timer_counter_modes
    import itc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        ref_clk;
    logic        reset;
    logic        cntClk;
    logic        gate;
    logic        ctrlWrite;
    itc_ctrl_s   ctrlWord;
    logic        dataWrite;
    logic [7:0]  dataIn;
    logic        dataRead;
    logic [7:0]  readData;
    logic        cntOut;
    logic [15:0] lows;
    logic [7:0]  rb;
    int          mismatches = 0;
    int          n_compared = 0;

    itc_counter u_dut (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .cntClk   (cntClk),
        .gate     (gate),
        .ctrlWrite(ctrlWrite),
        .ctrlWord (ctrlWord),
        .dataWrite(dataWrite),
        .dataIn   (dataIn),
        .dataRead (dataRead),
        .readData (readData),
        .cntOut   (cntOut)
    );

    itc_host_model u_host (
        .ref_clk  (ref_clk),
        .readData (readData),
        .ctrlWrite(ctrlWrite),
        .ctrlWord (ctrlWord),
        .dataWrite(dataWrite),
        .dataIn   (dataIn),
        .dataRead (dataRead)
    );

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Gives n counter clocks and counts those after which the output is not high.
    task automatic run(input int n);
        lows = 16'h0000;
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk) #1 cntClk = 1'b1;
            repeat (4) @(posedge ref_clk);
            #1 cntClk = 1'b0;
            repeat (4) @(posedge ref_clk);
            #1 if (cntOut !== 1'b1) lows = lows + 16'h0001;
        end
    endtask : run

    task automatic expLows(input int n, input logic [15:0] exp);
        run(n);
        chk("low samples", lows, exp);
    endtask : expLows

    task automatic testTerminal();
        gate = 1'b1;
        u_host.wrCtrl(MODE_TC, FMT_LSB);
        chk("cntOut", {15'h0000, cntOut}, 16'h0000);
        u_host.wrByte(8'h03);
        expLows(3, 16'h0003);
        expLows(3, 16'h0000);
        u_host.wrCtrl(MODE_TC, FMT_LSB);
        u_host.wrByte(8'h04);
        run(2);
        gate = 1'b0;
        run(3);
        gate = 1'b1;
        expLows(2, 16'h0002);
        expLows(1, 16'h0000);
        u_host.wrCtrl(MODE_TC, FMT_LSB);
        u_host.wrByte(8'h05);
        run(2);
        u_host.wrByte(8'h02);
        expLows(2, 16'h0002);
        expLows(1, 16'h0000);
        u_host.wrCtrl(MODE_TC, FMT_LSB);
        u_host.wrByte(8'h01);
        expLows(1, 16'h0001);
        expLows(1, 16'h0000);
    endtask : testTerminal

    task automatic testRate();
        gate = 1'b0;
        u_host.wrCtrl(MODE_RATE, FMT_LSB);
        chk("cntOut", {15'h0000, cntOut}, 16'h0001);
        u_host.wrByte(8'h03);
        expLows(3, 16'h0000);
        gate = 1'b1;
        expLows(10, 16'h0003);
        gate = 1'b0;
        expLows(4, 16'h0000);
        gate = 1'b1;
        expLows(10, 16'h0003);
    endtask : testRate

    task automatic testSquare();
        gate = 1'b1;
        u_host.wrCtrl(MODE_SQUARE, FMT_LSB);
        u_host.wrByte(8'h05);
        expLows(3, 16'h0000);
        expLows(2, 16'h0002);
        expLows(5, 16'h0002);
        gate = 1'b0;
        expLows(3, 16'h0000);
    endtask : testSquare

    task automatic testOneShot();
        logic [15:0] first;
        gate = 1'b0;
        u_host.wrCtrl(MODE_ONESHOT, FMT_LSB);
        chk("cntOut", {15'h0000, cntOut}, 16'h0001);
        u_host.wrByte(8'h03);
        expLows(3, 16'h0000);
        gate = 1'b1;
        run(2);
        first = lows;
        gate = 1'b0;
        u_host.wrByte(8'h05);
        run(7);
        chk("low samples", first + lows, 16'h0003);
        gate = 1'b1;
        expLows(9, 16'h0005);
    endtask : testOneShot

    task automatic testStrobe(input itc_mode_e mode);
        gate = (mode == MODE_SWSTROBE);
        u_host.wrCtrl(mode, FMT_LSB);
        chk("cntOut", {15'h0000, cntOut}, 16'h0001);
        u_host.wrByte(8'h03);
        expLows(3, 16'h0000);
        gate = 1'b1;
        expLows(8, 16'h0001);
    endtask : testStrobe

    task automatic testRestart();
        gate = 1'b1;
        u_host.wrCtrl(MODE_SWSTROBE, FMT_LSB);
        u_host.wrByte(8'h04);
        run(3);
        gate = 1'b0;
        run(2);
        gate = 1'b1;
        expLows(3, 16'h0000);
        expLows(3, 16'h0001);
    endtask : testRestart

    task automatic testLatch();
        gate = 1'b1;
        u_host.wrCtrl(MODE_TC, FMT_BOTH);
        u_host.wrWord(16'h1234);
        run(5);
        u_host.wrCtrl(MODE_TC, FMT_LATCH);
        run(2);
        u_host.rdByte(rb);
        chk("latched low", {8'h00, rb}, 16'h0030);
        u_host.rdByte(rb);
        chk("latched high", {8'h00, rb}, 16'h0012);
        gate = 1'b0;
        u_host.rdByte(rb);
        chk("live low", {8'h00, rb}, 16'h002e);
        u_host.rdByte(rb);
        chk("live high", {8'h00, rb}, 16'h0012);
    endtask : testLatch

    task automatic testAlias();
        gate = 1'b1;
        u_host.wrCtrl(MODE_TC, FMT_MSB);
        u_host.wrByte(8'h01);
        run(1);
        chk("cntOut", {15'h0000, cntOut}, 16'h0000);
        gate = 1'b0;
        u_host.rdByte(rb);
        chk("live msb", {8'h00, rb}, 16'h0001);
        u_host.wrCtrl(3'h6, FMT_LSB);
        u_host.wrByte(8'h02);
        gate = 1'b1;
        expLows(5, 16'h0002);
        u_host.wrByte(8'h04);
        expLows(4, 16'h0001);
        u_host.wrCtrl(3'h7, FMT_LSB);
        u_host.wrByte(8'h04);
        expLows(4, 16'h0002);
    endtask : testAlias

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        summarize();
    end

    initial begin
        reset  = 1'b1;
        cntClk = 1'b0;
        gate   = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 reset = 1'b0;
        chk("cntOut", {15'h0000, cntOut}, 16'h0001);
        chk("readData", {8'h00, readData}, 16'h0000);
        testTerminal();
        testRate();
        testSquare();
        testOneShot();
        testStrobe(MODE_SWSTROBE);
        testStrobe(MODE_HWSTROBE);
        testRestart();
        testLatch();
        testAlias();
        summarize();
    end

endmodule : test_interval_timer_counter_modes
